// ==== design/sas_pkg.sv ====
package sas_pkg;
	// ==========================================================
	// Register map (byte addresses, one aligned word each)
	// ==========================================================
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_TIME = 8'h08;
	localparam logic [7:0] ADDR_POS = 8'h0C;
	localparam logic [7:0] ADDR_TGT = 8'h10;
	localparam logic [7:0] ADDR_TOL = 8'h14;
	localparam logic [7:0] ADDR_STAT = 8'h18;
	localparam logic [7:0] ADDR_ERR = 8'h1C;
	localparam logic [7:0] ADDR_COUNT = 8'h20;
	localparam logic [7:0] ADDR_STEP = 8'h24;

	// ==========================================================
	// Control register fields (write one to act, self clearing except CTRL_KEY_REF, which holds until written zero)
	// ==========================================================
	localparam int CTRL_START = 0;
	localparam int CTRL_KEY_REF = 1;
	localparam int CTRL_IN_POS = 2;
	localparam int CTRL_RET_DONE = 3;
	localparam int CTRL_REF_DONE = 4;
	localparam int CTRL_CUT_LEN = 5;
	localparam int CTRL_PROG_MODE = 6;

	// ==========================================================
	// Config register fields
	// ==========================================================
	localparam int CFG_RET_LSB = 0;
	localparam int CFG_REF_LSB = 4;
	localparam int CFG_SWMIN_LSB = 8;
	localparam int CFG_SWMAX_LSB = 12;
	localparam int CFG_MEAS_LSB = 16;
	localparam int CFG_THICK_BAD = 20;
	localparam int CFG_LAST_LSB = 24;

	// ==========================================================
	// Timing and reset values
	// ==========================================================
	localparam int CLK_HZ = 10_000_000;
	localparam int KEY_HOLD_S = 2;
	localparam int KEY_HOLD_CYC = KEY_HOLD_S * CLK_HZ + 1;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [31:0] TIME_RST = 32'h0000_0000;
	localparam logic [2:0] REF_MODE_PT_LO = 3'h5;
	localparam logic [2:0] REF_MODE_PT_HI = 3'h6;
	localparam logic [4:0] ERR_NONE = 5'h00;

	// ==========================================================
	// Positioning state
	// ==========================================================
	typedef enum logic [2:0] {
		SAS_IDLE = 3'b000,
		SAS_POSN = 3'b001,
		SAS_HOLD = 3'b010,
		SAS_RETR = 3'b011,
		SAS_REFR = 3'b100
	} sas_state_t;
endpackage

// ==== design/sas_supervisor.sv ====
`timescale 1ns/1ps
module sas_supervisor (
	input wire logic clk,
	input wire logic reset_n,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Machine inputs, asynchronous
	input wire logic [2:0] lim_min,
	input wire logic [2:0] lim_max,
	input wire logic ext_stop,
	input wire logic ext_start,
	input wire logic retract_in,
	input wire logic ref_start_in,
	input wire logic ref_point_in,
	input wire logic quantity_in,
	input wire logic next_step_in,
	input wire logic cut_in_process,
	input wire logic [2:0] axis_arrived,
	// Status outputs
	output logic ctrl_enable,
	output logic pos_reached,
	output logic tol_zone,
	output logic retract_run,
	output logic ref_run,
	output logic qty_reached,
	output logic cut_enable,
	output logic cut_len_reached,
	output logic prog_mode,
	output logic prog_end,
	output logic ref_calibrate,
	output logic [4:0] err_code
);
	localparam int NSYNC = 19;

	// ==========================================================
	// Whole state
	typedef struct packed {
		logic [NSYNC-1:0] s1; // First sync stage
		logic [NSYNC-1:0] s2; // Second sync stage
		logic [NSYNC-1:0] s3; // Delayed copy for edges
		sas_pkg::sas_state_t st; // Positioning state
		logic [31:0] cfg; // Modes and soft faults
		logic [31:0] tim; // Delay[15:0], pulse[23:16], qty[31:24]
		logic [31:0] pos; // Actual position
		logic [31:0] tgt; // Target position
		logic [31:0] tol; // Tolerance half band
		logic [15:0] qty_goal; // Pieces wanted
		logic [15:0] count; // Pieces counted
		logic [7:0] step; // Program step
		logic [31:0] key_cnt; // Reference key hold timer
		logic key_used; // Hold already fired
		logic [15:0] dly_cnt; // Axis delay timer
		logic [7:0] pr_cnt; // Position reached pulse timer
		logic [7:0] qr_cnt; // Quantity pulse timer
		logic pr; // Position reached output
		logic qr; // Quantity reached output
		logic cal; // Calibration pulse
		logic cut_len; // Cut length latched
		logic pmode; // Program mode
		logic aw_ok; // Write address held
		logic w_ok; // Write data held
		logic [7:0] awa; // Held write address
		logic [31:0] wd; // Held write data
		logic [3:0] ws; // Held write strobes, travel with the data
		logic bv; // Write response valid
		logic rv; // Read data valid
		logic [31:0] rd; // Read data
		logic [1:0] rr; // Read response
		logic [6:0] ctl; // Control pulses this cycle
	} sas_reg_t;

	sas_reg_t q_ff;
	sas_reg_t nxt_q;

	// Synchronised view and edges
	logic [NSYNC-1:0] in_s;
	logic [NSYNC-1:0] in_rise;
	logic [16:0] err_vec;

	assign in_s = q_ff.s2;
	assign in_rise = q_ff.s2 & ~q_ff.s3;

	// ==========================================================
	// Lowest active code wins
	function automatic logic [4:0] lowest_err(input logic [16:0] v);
		logic [4:0] r;
		r = sas_pkg::ERR_NONE;
		for (int i = 16; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i + 1);
			end
		end
		return r;
	endfunction

	// Write merge by byte lanes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Error vector: bit n is code n+1
	assign err_vec = {q_ff.cfg[sas_pkg::CFG_THICK_BAD], in_s[6],
		q_ff.cfg[sas_pkg::CFG_MEAS_LSB +: 3], q_ff.cfg[sas_pkg::CFG_SWMAX_LSB +: 3],
		q_ff.cfg[sas_pkg::CFG_SWMIN_LSB +: 3], in_s[5:0]};

	// ==========================================================
	// Next state
	always_comb begin
		logic [2:0] rmode;
		logic stop;
		logic go;
		logic key_fire;
		logic wr;
		nxt_q = q_ff;
		wr = 1'b0;
		go = 1'b0;
		key_fire = 1'b0;
		rmode = q_ff.cfg[sas_pkg::CFG_REF_LSB +: 3];
		stop = in_s[6];
		// Input map: 0-5 limits, 6 stop, 7 start, 8 retract, 9 ref, 10 point,
		// 11 qty, 12 next, 13 cut, 14-15 spare, 16-18 axis arrived
		nxt_q.s1 = {axis_arrived, 2'b00, cut_in_process, next_step_in, quantity_in, ref_point_in,
			ref_start_in, retract_in, ext_start, ext_stop, lim_max, lim_min};
		nxt_q.s2 = q_ff.s1;
		nxt_q.s3 = q_ff.s2;
		nxt_q.ctl = 7'h00;
		nxt_q.cal = 1'b0;

		// Bus write capture, address and data in either order
		if (s_axi_awvalid && !q_ff.aw_ok) begin
			nxt_q.aw_ok = 1'b1;
			nxt_q.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q_ff.w_ok) begin
			nxt_q.w_ok = 1'b1;
			nxt_q.wd = s_axi_wdata;
			nxt_q.ws = s_axi_wstrb;
		end
		wr = q_ff.aw_ok && q_ff.w_ok && !q_ff.bv;
		if (wr) begin
			nxt_q.aw_ok = 1'b0;
			nxt_q.w_ok = 1'b0;
			nxt_q.bv = 1'b1;
			case (q_ff.awa)
				sas_pkg::ADDR_CTRL: nxt_q.ctl = q_ff.wd[6:0];
				sas_pkg::ADDR_CFG: nxt_q.cfg = merge(q_ff.cfg, q_ff.wd, q_ff.ws);
				sas_pkg::ADDR_TIME: nxt_q.tim = merge(q_ff.tim, q_ff.wd, q_ff.ws);
				sas_pkg::ADDR_POS: nxt_q.pos = merge(q_ff.pos, q_ff.wd, q_ff.ws);
				sas_pkg::ADDR_TGT: nxt_q.tgt = merge(q_ff.tgt, q_ff.wd, q_ff.ws);
				sas_pkg::ADDR_TOL: nxt_q.tol = merge(q_ff.tol, q_ff.wd, q_ff.ws);
				sas_pkg::ADDR_COUNT: nxt_q.qty_goal = q_ff.wd[31:16];
				default: nxt_q.bv = 1'b1; // Unmapped writes are ignored, OKAY
			endcase
		end
		if (q_ff.bv && s_axi_bready) begin
			nxt_q.bv = 1'b0;
		end

		// Bus read
		if (s_axi_arvalid && !q_ff.rv) begin
			nxt_q.rv = 1'b1;
			nxt_q.rr = 2'b00;
			case (s_axi_araddr)
				sas_pkg::ADDR_CTRL: nxt_q.rd = {25'h0, q_ff.pmode, 6'h00};
				sas_pkg::ADDR_CFG: nxt_q.rd = q_ff.cfg;
				sas_pkg::ADDR_TIME: nxt_q.rd = q_ff.tim;
				sas_pkg::ADDR_POS: nxt_q.rd = q_ff.pos;
				sas_pkg::ADDR_TGT: nxt_q.rd = q_ff.tgt;
				sas_pkg::ADDR_TOL: nxt_q.rd = q_ff.tol;
				sas_pkg::ADDR_STAT: nxt_q.rd = {13'h0000, in_s};
				sas_pkg::ADDR_ERR: nxt_q.rd = {15'h0000, err_vec};
				sas_pkg::ADDR_COUNT: nxt_q.rd = {q_ff.qty_goal, q_ff.count};
				sas_pkg::ADDR_STEP: nxt_q.rd = {21'h0, q_ff.st, q_ff.step};
				default: begin
					nxt_q.rd = 32'h0000_0000;
					nxt_q.rr = 2'b10; // SLVERR on unmapped reads
				end
			endcase
		end
		if (q_ff.rv && s_axi_rready) begin
			nxt_q.rv = 1'b0;
		end

		// Reference key held over two seconds fires once per press
		if (!q_ff.ctl[sas_pkg::CTRL_KEY_REF] && !nxt_q.ctl[sas_pkg::CTRL_KEY_REF]) begin
			nxt_q.key_cnt = 32'h0000_0000;
			nxt_q.key_used = 1'b0;
		end
		if (q_ff.ctl[sas_pkg::CTRL_KEY_REF]) begin
			nxt_q.ctl[sas_pkg::CTRL_KEY_REF] = 1'b1; // Level until software writes zero
			if (wr && q_ff.awa == sas_pkg::ADDR_CTRL) begin
				nxt_q.ctl[sas_pkg::CTRL_KEY_REF] = q_ff.wd[sas_pkg::CTRL_KEY_REF];
			end
			nxt_q.key_cnt = q_ff.key_cnt + 32'h0000_0001;
			if (q_ff.key_cnt == 32'(sas_pkg::KEY_HOLD_CYC) && !q_ff.key_used) begin
				key_fire = 1'b1;
				nxt_q.key_used = 1'b1;
			end
		end

		// External start and panel start are one command
		go = (in_rise[7] || q_ff.ctl[sas_pkg::CTRL_START]) && !stop;

		// Piece counter on rising edges only
		if (in_rise[11]) begin
			nxt_q.count = q_ff.count + 16'h0001;
			if (q_ff.count + 16'h0001 == q_ff.qty_goal) begin
				nxt_q.qr = 1'b1;
				nxt_q.qr_cnt = q_ff.tim[31:24];
			end
		end
		if (q_ff.qr && q_ff.tim[31:24] != 8'h00 && !in_rise[11]) begin
			if (q_ff.qr_cnt <= 8'h01) begin
				nxt_q.qr = 1'b0;
			end else begin
				nxt_q.qr_cnt = q_ff.qr_cnt - 8'h01;
			end
		end

		// Program step and mode
		if (q_ff.ctl[sas_pkg::CTRL_PROG_MODE]) begin
			nxt_q.pmode = ~q_ff.pmode;
		end
		if (in_rise[12] && q_ff.step != q_ff.cfg[sas_pkg::CFG_LAST_LSB +: 8]) begin
			nxt_q.step = q_ff.step + 8'h01;
		end
		// A new length report in the cycle of a cut start wins
		if (in_rise[13]) begin
			nxt_q.cut_len = 1'b0;
		end
		if (q_ff.ctl[sas_pkg::CTRL_CUT_LEN]) begin
			nxt_q.cut_len = 1'b1;
		end

		// Position reached pulse timing
		if (q_ff.pr && q_ff.tim[23:16] != 8'h00) begin
			if (q_ff.pr_cnt <= 8'h01) begin
				nxt_q.pr = 1'b0;
			end else begin
				nxt_q.pr_cnt = q_ff.pr_cnt - 8'h01;
			end
		end

		// Positioning machine
		case (q_ff.st)
			sas_pkg::SAS_IDLE: begin
				if (stop) begin
					nxt_q.st = sas_pkg::SAS_IDLE;
				end else if (in_s[8]) begin
					nxt_q.st = sas_pkg::SAS_RETR;
				end else if (key_fire) begin
					nxt_q.st = sas_pkg::SAS_REFR;
				end else if (in_rise[9]) begin
					nxt_q.cal = rmode != 3'h0 && rmode < 3'h3;
				end else if (go) begin
					nxt_q.st = sas_pkg::SAS_POSN;
					nxt_q.pr = 1'b0;
				end
			end
			sas_pkg::SAS_POSN: begin
				if (stop) begin
					nxt_q.st = sas_pkg::SAS_IDLE;
				end else if (q_ff.ctl[sas_pkg::CTRL_IN_POS]) begin
					nxt_q.st = sas_pkg::SAS_HOLD;
					nxt_q.dly_cnt = q_ff.tim[15:0];
					nxt_q.pr = 1'b1;
					nxt_q.pr_cnt = q_ff.tim[23:16];
				end
			end
			sas_pkg::SAS_HOLD: begin
				if (stop || q_ff.dly_cnt == 16'h0000) begin
					nxt_q.st = sas_pkg::SAS_IDLE;
				end else begin
					nxt_q.dly_cnt = q_ff.dly_cnt - 16'h0001;
				end
			end
			sas_pkg::SAS_RETR: begin
				if (stop || !in_s[8] || q_ff.ctl[sas_pkg::CTRL_RET_DONE]) begin
					nxt_q.st = sas_pkg::SAS_IDLE;
				end
			end
			sas_pkg::SAS_REFR: begin
				// Point input ends the run only in modes five and six
				if (stop || q_ff.ctl[sas_pkg::CTRL_REF_DONE] ||
					(in_rise[10] && (rmode == sas_pkg::REF_MODE_PT_LO ||
					rmode == sas_pkg::REF_MODE_PT_HI))) begin
					nxt_q.st = sas_pkg::SAS_IDLE;
				end
			end
			default: nxt_q.st = sas_pkg::SAS_IDLE;
		endcase
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q_ff <= '0;
			q_ff.cfg <= sas_pkg::CFG_RST;
			q_ff.tim <= sas_pkg::TIME_RST;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// ==========================================================
	// Outputs
	assign s_axi_awready = !q_ff.aw_ok;
	assign s_axi_wready = !q_ff.w_ok;
	assign s_axi_bvalid = q_ff.bv;
	assign s_axi_bresp = 2'b00;
	assign s_axi_arready = !q_ff.rv;
	assign s_axi_rvalid = q_ff.rv;
	assign s_axi_rdata = q_ff.rd;
	assign s_axi_rresp = q_ff.rr;
	assign ctrl_enable = q_ff.st == sas_pkg::SAS_POSN || q_ff.st == sas_pkg::SAS_HOLD;
	assign pos_reached = q_ff.pr;
	assign tol_zone = (((q_ff.pos > q_ff.tgt) ? q_ff.pos - q_ff.tgt
		: q_ff.tgt - q_ff.pos) <= q_ff.tol);
	assign retract_run = q_ff.st == sas_pkg::SAS_RETR;
	assign ref_run = q_ff.st == sas_pkg::SAS_REFR;
	assign qty_reached = q_ff.qr;
	assign cut_enable = (&in_s[18:16]) && q_ff.st != sas_pkg::SAS_POSN;
	assign cut_len_reached = q_ff.cut_len;
	assign prog_mode = q_ff.pmode;
	assign prog_end = q_ff.pmode && q_ff.step == q_ff.cfg[sas_pkg::CFG_LAST_LSB +: 8];
	assign ref_calibrate = q_ff.cal;
	assign err_code = lowest_err(err_vec);

	// ==========================================================
	// Checks
	chk_stop_halts: assert property (@(posedge clk) disable iff (!reset_n)
		in_s[6] |=> !(q_ff.st == sas_pkg::SAS_POSN)) else $error("stop did not halt");
	chk_stop_code: assert property (@(posedge clk) disable iff (!reset_n)
		in_s[6] && err_vec[14:0] == 15'h0 |-> err_code == 5'h10) else $error("code 16 missing");
	chk_limit_code: assert property (@(posedge clk) disable iff (!reset_n)
		in_s[0] |-> err_code == 5'h01) else $error("code 1 missing");
	chk_count_edge: assert property (@(posedge clk) disable iff (!reset_n)
		in_rise[11] |=> q_ff.count == $past(q_ff.count) + 16'h0001) else $error("count miss");
	chk_count_level: assert property (@(posedge clk) disable iff (!reset_n)
		!in_rise[11] |=> q_ff.count == $past(q_ff.count)) else $error("count on level");
	chk_ret_out: assert property (@(posedge clk) disable iff (!reset_n)
		retract_run && !in_s[8] |=> !retract_run) else $error("retract held");
	chk_ext_ref: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(ref_run) |-> q_ff.key_used) else $error("ref start");
	chk_pr_static: assert property (@(posedge clk) disable iff (!reset_n)
		pos_reached && q_ff.tim[23:16] == 8'h00 && q_ff.st != sas_pkg::SAS_IDLE |=> pos_reached)
		else $error("static lost");
endmodule

// ==== sim/sas_machine.sv ====
`timescale 1ns/1ps
// ==========================================================
// Machine side: axis drives and knife bar
// ==========================================================
module sas_machine #(
	parameter int KNIFE_LAG = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cut_enable,
	input wire logic [2:0] arrive_mask,
	output logic [2:0] axis_arrived,
	output logic cut_in_process
);
	logic [3:0] knife_ff; // Knife stroke phase, zero at top
	// Drives report arrival one cycle late, as a real drive would
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			axis_arrived <= 3'h0;
			knife_ff <= 4'h0;
		end else begin
			axis_arrived <= arrive_mask;
			// Stroke starts on cut enable and always completes
			if (knife_ff != 4'h0 || cut_enable)
				knife_ff <= knife_ff + 4'h1;
		end
	end
	// Flag raised only once the bar is well clear of the top
	assign cut_in_process = (knife_ff > 4'(KNIFE_LAG));
endmodule

// ==== sim/sas_supervisor_tb.sv ====
`timescale 1ns/1ps
// ==========================================================
// Bench for the shear supervisor
// ==========================================================
module sas_supervisor_tb;
	logic clk, reset_n;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [2:0] lim_min, lim_max, axis_arrived, arrive_mask;
	logic ext_stop, ext_start, retract_in, ref_start_in, ref_point_in, quantity_in;
	logic next_step_in, cut_in_process, ctrl_enable, pos_reached, tol_zone, retract_run;
	logic ref_run, qty_reached, cut_enable, cut_len_reached, prog_mode, prog_end, ref_calibrate;
	logic [4:0] err_code;
	int error_cnt, num_checks, cyc, n;

	sas_supervisor sas_supervisor_inst (.clk(clk), .reset_n(reset_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .lim_min(lim_min),
		.lim_max(lim_max), .ext_stop(ext_stop), .ext_start(ext_start), .retract_in(retract_in),
		.ref_start_in(ref_start_in), .ref_point_in(ref_point_in), .quantity_in(quantity_in),
		.next_step_in(next_step_in), .cut_in_process(cut_in_process),
		.axis_arrived(axis_arrived), .ctrl_enable(ctrl_enable), .pos_reached(pos_reached),
		.tol_zone(tol_zone), .retract_run(retract_run), .ref_run(ref_run),
		.qty_reached(qty_reached), .cut_enable(cut_enable), .cut_len_reached(cut_len_reached),
		.prog_mode(prog_mode), .prog_end(prog_end), .ref_calibrate(ref_calibrate),
		.err_code(err_code));

	sas_machine sas_machine_inst (.clk(clk), .reset_n(reset_n), .cut_enable(cut_enable),
		.arrive_mask(arrive_mask), .axis_arrived(axis_arrived), .cut_in_process(cut_in_process));

	// ==========================================================
	// Clock and hang guard
	// ==========================================================
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Whole run needs under a thousand cycles; far beyond that is a hang
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end

	// ==========================================================
	// Bus and compare helpers
	// ==========================================================
	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (!aw_done && s_axi_awready === 1'b1) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw_done && w_done));
		while (s_axi_bvalid !== 1'b1) @(posedge clk);
		s_axi_bready <= 1'b0;
	endtask
	// Read: response taken at the edge rvalid is seen
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge clk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic settle();
		repeat (6) @(posedge clk);
	endtask
	// Config bit for error index i (codes 7 to 15 and 17)
	function automatic int cbit(input int i);
		return (i < 9) ? i + 2 : (i < 12) ? i + 3 : (i < 15) ? i + 4 : 20;
	endfunction

	// ==========================================================
	// Scenarios
	// ==========================================================
	initial begin
		reset_n = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		{lim_min, lim_max, arrive_mask} = '0;
		{ext_stop, ext_start, retract_in, ref_start_in, ref_point_in, quantity_in} = '0;
		next_step_in = 1'b0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		settle();
		chk({ctrl_enable, pos_reached, retract_run, ref_run, tol_zone, err_code}, 32'h0000_0020,
			"reset outputs");
		// Each error source alone, then cleared
		for (int i = 0; i < 17; i++) begin
			if (i < 6)
				{lim_max, lim_min} <= 6'h01 << i;
			else if (i == 15)
				ext_stop <= 1'b1;
			else
				wr(sas_pkg::ADDR_CFG, 32'h0000_0001 << cbit(i));
			settle();
			chk(32'(err_code), 32'(i + 1), "error code");
			rd(sas_pkg::ADDR_ERR);
			chk(d, 32'h0000_0001 << i, "error word");
			{lim_max, lim_min} <= 6'h00;
			ext_stop <= 1'b0;
			wr(sas_pkg::ADDR_CFG, 32'h0000_0000);
		end
		// Several at once: lowest code wins
		lim_max <= 3'h4;
		ext_stop <= 1'b1;
		wr(sas_pkg::ADDR_CFG, 32'h0010_0100);
		settle();
		chk(32'(err_code), 32'h0000_0006, "priority");
		lim_max <= 3'h0;
		wr(sas_pkg::ADDR_CFG, 32'h0000_0000);
		// Start refused under stop, external start, stop halts
		wr(sas_pkg::ADDR_CTRL, 32'h0000_0001);
		settle();
		chk(ctrl_enable, 1'b0, "start under stop");
		ext_stop <= 1'b0;
		ext_start <= 1'b1;
		settle();
		ext_start <= 1'b0;
		chk(ctrl_enable, 1'b1, "external start");
		ext_stop <= 1'b1;
		settle();
		chk(ctrl_enable, 1'b0, "stop halts");
		ext_stop <= 1'b0;
		// Panel start, position reached pulse, delayed enable drop
		wr(sas_pkg::ADDR_TIME, 32'h0003_0028);
		wr(sas_pkg::ADDR_CTRL, 32'h0000_0001);
		settle();
		chk(ctrl_enable, 1'b1, "panel start");
		n = 0;
		fork
			wr(sas_pkg::ADDR_CTRL, 32'h0000_0004);
			repeat (25) begin
				@(posedge clk);
				n += int'(pos_reached === 1'b1);
			end
		join
		chk(32'(n), 32'h0000_0003, "reached pulse");
		chk(ctrl_enable, 1'b1, "enable during delay");
		repeat (40) @(posedge clk);
		chk(ctrl_enable, 1'b0, "enable dropped");
		// Zero pulse time gives a steady reached level
		wr(sas_pkg::ADDR_TIME, 32'h0000_0005);
		wr(sas_pkg::ADDR_CTRL, 32'h0000_0001);
		wr(sas_pkg::ADDR_CTRL, 32'h0000_0004);
		repeat (12) @(posedge clk);
		chk({ctrl_enable, pos_reached}, 2'b01, "static reached");
		// Retract follows its input
		retract_in <= 1'b1;
		settle();
		chk(retract_run, 1'b1, "retract on");
		retract_in <= 1'b0;
		settle();
		chk(retract_run, 1'b0, "retract off");
		// Reference input: calibrate in mode 1, never a run in mode 3
		wr(sas_pkg::ADDR_CFG, 32'h0000_0030);
		ref_start_in <= 1'b1;
		settle();
		ref_start_in <= 1'b0;
		chk(ref_run, 1'b0, "no run from input");
		wr(sas_pkg::ADDR_CFG, 32'h0000_0010);
		n = 0;
		for (int k = 0; k < 10; k++) begin
			ref_start_in <= (k < 2);
			@(posedge clk);
			n += int'(ref_calibrate === 1'b1);
		end
		chk(32'(n), 32'h0000_0001, "calibrate once");
		// Quantity: one long level then two short pulses, level output
		wr(sas_pkg::ADDR_COUNT, 32'h0003_0000);
		for (int k = 0; k < 3; k++) begin
			quantity_in <= 1'b1;
			repeat (k == 0 ? 20 : 4) @(posedge clk);
			quantity_in <= 1'b0;
			settle();
		end
		rd(sas_pkg::ADDR_COUNT);
		chk(d & 32'h0000_ffff, 32'h0000_0003, "piece count");
		chk(qty_reached, 1'b1, "quantity level");
		// Program mode, next step to last step
		wr(sas_pkg::ADDR_CFG, 32'h0100_0000);
		wr(sas_pkg::ADDR_CTRL, 32'h0000_0040);
		next_step_in <= 1'b1;
		settle();
		next_step_in <= 1'b0;
		settle();
		rd(sas_pkg::ADDR_STEP);
		chk(d & 32'h0000_00ff, 32'h0000_0001, "program step");
		chk({prog_mode, prog_end}, 2'b11, "program outputs");
		// Cut enable only with every axis arrived
		arrive_mask <= 3'h3;
		settle();
		chk(cut_enable, 1'b0, "partial arrival");
		arrive_mask <= 3'h7;
		settle();
		chk(cut_enable, 1'b1, "all arrived");
		// Let the knife finish its stroke and rest before reporting length
		arrive_mask <= 3'h0;
		repeat (24) @(posedge clk);
		wr(sas_pkg::ADDR_CTRL, 32'h0000_0020);
		settle();
		chk(cut_len_reached, 1'b1, "cut length");
		arrive_mask <= 3'h7;
		repeat (16) @(posedge clk);
		chk(cut_len_reached, 1'b0, "cut under way");
		// Tolerance band inside and outside
		wr(sas_pkg::ADDR_POS, 32'h0000_0064);
		wr(sas_pkg::ADDR_TGT, 32'h0000_0069);
		wr(sas_pkg::ADDR_TOL, 32'h0000_000a);
		chk(tol_zone, 1'b1, "inside band");
		wr(sas_pkg::ADDR_POS, 32'h0000_00c8);
		chk(tol_zone, 1'b0, "outside band");
		// Unmapped read answers an error and zero
		rd(8'h40);
		chk(32'(r), 32'h0000_0002, "unmapped response");
		chk(d, 32'h0000_0000, "unmapped data");
		finish_test();
	end
endmodule
